// ### common/aci_pkg.sv
// Constants and types shared by the auxiliary control input logic.
package aci_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  // Longest reference period accepted before lock is declared lost.
  localparam int unsigned REF_TIMEOUT_NS  = 66_666_667;
  localparam int unsigned REF_TIMEOUT_CYC = REF_TIMEOUT_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMEOUT_W       = 24;

  // ----------------------------------------------------------------
  // Synchroniser and input bit positions
  // ----------------------------------------------------------------
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned IN_W        = 3;
  localparam int unsigned IN_ILK      = 0;
  localparam int unsigned IN_TRIG     = 1;
  localparam int unsigned IN_REF      = 2;

  // ----------------------------------------------------------------
  // Waveform phase accumulator and lock loop
  // ----------------------------------------------------------------
  localparam int unsigned PHASE_W          = 32;
  localparam int unsigned RANGE_DEFAULT_HZ = 10;
  localparam logic [PHASE_W-1:0] RANGE_DEFAULT_INC =
    PHASE_W'((64'(RANGE_DEFAULT_HZ) << PHASE_W) / 64'(CLK_HZ));
  localparam int unsigned PHASE_GAIN_SHIFT = 2;
  localparam int unsigned FREQ_GAIN_SHIFT  = 12;
  localparam logic [PHASE_W-1:0] LOCK_TOL  = 32'h0100_0000;
  localparam int unsigned LOCK_CNT_W       = 3;
  localparam logic [LOCK_CNT_W-1:0] LOCK_EDGES = 3'h4;
  localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_ZERO = 3'h0;

  // ----------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACI_MODE_DISABLED,
    ACI_MODE_INHIBIT,
    ACI_MODE_REMOTE_ON
  } aci_mode_t;

  typedef enum logic [1:0] {
    ACI_TR_IDLE,
    ACI_TR_WAITING,
    ACI_TR_RUNNING
  } aci_tr_state_t;

endpackage

// ### rtl/aci_sync2.sv
// Two-stage synchroniser, one chain per input bit.
`timescale 1ns/1ps
module aci_sync2 #(
  parameter int unsigned WIDTH = aci_pkg::IN_W
) (
  input  wire logic             clk_sys, // System clock.
  input  wire logic             reset,   // Synchronous reset, active high.
  input  wire logic [WIDTH-1:0] async_in, // Raw pin levels.
  output logic      [WIDTH-1:0] sync_out  // Levels retimed to clk_sys.
);
  import aci_pkg::*;

  logic [WIDTH-1:0] stage1;

  // ----------------------------------------------------------------
  // Per-bit chains
  // ----------------------------------------------------------------
  // Only the second flop reads the first; nothing else may look at it.
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge clk_sys) begin
      if (reset) begin
        stage1[i]   <= 1'b0;
        sync_out[i] <= 1'b0;
      end else begin
        stage1[i]   <= async_in[i];
        sync_out[i] <= stage1[i];
      end
    end
  end

endmodule

// ### rtl/aci_ctrl.sv
// Interlock, transient trigger and phase reference control for the auxiliary inputs.
`timescale 1ns/1ps
module aci_ctrl #(
  parameter int unsigned REF_TIMEOUT_CYCLES = aci_pkg::REF_TIMEOUT_CYC
) (
  input  wire logic                         clk_sys,                // System clock, 100 MHz.
  input  wire logic                         reset,                  // Synchronous reset, active high.
  input  wire logic                         interlock_pins,         // High while interlock pins shorted.
  input  wire logic                         external_trigger_pin,   // Transient trigger input.
  input  wire logic                         phase_ref_pin,          // External phase reference input.
  input  wire logic                         interlock_mode_setting, // 1 selects inhibit mode.
  input  wire logic                         remote_on_mode_setting, // 1 selects remote-on mode.
  input  wire logic                         output_on_cmd,          // Enable request pulse.
  input  wire logic                         output_off_cmd,         // Disable request pulse.
  input  wire logic                         fault_clear,            // Clears interlock fault.
  input  wire logic                         trig_input_setting,     // Trigger input mode active.
  input  wire logic                         program_launch,         // Transient program executed.
  input  wire logic                         program_abort,          // Stop transient program.
  input  wire logic                         program_done,           // Transient program finished.
  input  wire logic                         ext_sync_enable,        // Lock to phase reference.
  input  wire logic [aci_pkg::PHASE_W-1:0]  freq_setpoint_inc,      // Setpoint phase step.
  input  wire logic [aci_pkg::PHASE_W-1:0]  freq_range_inc,         // Range step, 0 gives default.
  input  wire logic [aci_pkg::PHASE_W-1:0]  phase_shift,            // Phase A offset to reference.
  input  wire logic [aci_pkg::PHASE_W-1:0]  angle_b,                // Phase B angle from A.
  input  wire logic [aci_pkg::PHASE_W-1:0]  angle_c,                // Phase C angle from A.
  output logic                              output_enable,          // Output stage enabled.
  output logic                              interlock_fault,        // Sticky interlock fault.
  output aci_pkg::aci_mode_t                interlock_mode,         // Mode in effect.
  output logic                              transient_running,      // Waiting or executing.
  output logic                              progress_hold,          // Progress held at zero.
  output logic                              transient_start,        // One-cycle start pulse.
  output logic                              sync_locked,            // Reference lock status.
  output logic [aci_pkg::PHASE_W-1:0]       phase_a,                // Phase A accumulator.
  output logic [aci_pkg::PHASE_W-1:0]       phase_b,                // Phase B phase.
  output logic [aci_pkg::PHASE_W-1:0]       phase_c,                // Phase C phase.
  output logic [aci_pkg::PHASE_W-1:0]       phase_inc               // Active phase step.
);
  import aci_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisation
  // ----------------------------------------------------------------
  logic [IN_W-1:0] pins_sync;
  logic            ilk_shorted;
  logic            trig_prev;
  logic            ref_prev;
  logic            trig_rise;
  logic            ref_rise;

  aci_sync2 #(.WIDTH(IN_W)) u_sync (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .async_in ({phase_ref_pin, external_trigger_pin, interlock_pins}),
    .sync_out (pins_sync)
  );

  assign ilk_shorted = pins_sync[IN_ILK];
  assign trig_rise   = pins_sync[IN_TRIG] & ~trig_prev;
  assign ref_rise    = pins_sync[IN_REF] & ~ref_prev;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      trig_prev <= 1'b0;
      ref_prev  <= 1'b0;
    end else begin
      trig_prev <= pins_sync[IN_TRIG];
      ref_prev  <= pins_sync[IN_REF];
    end
  end

  // ----------------------------------------------------------------
  // Interlock mode and output enable
  // ----------------------------------------------------------------
  // Inhibit wins when both settings are set, as it is the safe choice.
  aci_mode_t next_mode;

  always_comb begin
    if (interlock_mode_setting) begin
      next_mode = ACI_MODE_INHIBIT;
    end else if (remote_on_mode_setting) begin
      next_mode = ACI_MODE_REMOTE_ON;
    end else begin
      next_mode = ACI_MODE_DISABLED;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      interlock_mode <= ACI_MODE_DISABLED;
    end else begin
      interlock_mode <= next_mode;
    end
  end

  logic ilk_trip;
  assign ilk_trip = (interlock_mode == ACI_MODE_INHIBIT) && output_enable && !ilk_shorted;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      output_enable <= 1'b0;
    end else begin
      case (interlock_mode)
        ACI_MODE_REMOTE_ON: begin
          output_enable <= ilk_shorted;
        end
        ACI_MODE_INHIBIT: begin
          if (ilk_trip || output_off_cmd) begin
            output_enable <= 1'b0;
          end else if (output_on_cmd && ilk_shorted && !interlock_fault) begin
            output_enable <= 1'b1;
          end
        end
        default: begin
          if (output_off_cmd) begin
            output_enable <= 1'b0;
          end else if (output_on_cmd && !interlock_fault) begin
            output_enable <= 1'b1;
          end
        end
      endcase
    end
  end

  // A trip in the same cycle as a clear keeps the fault set.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      interlock_fault <= 1'b0;
    end else if (ilk_trip) begin
      interlock_fault <= 1'b1;
    end else if (fault_clear) begin
      interlock_fault <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Transient trigger sequencing
  // ----------------------------------------------------------------
  aci_tr_state_t tr_state;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tr_state <= ACI_TR_IDLE;
    end else if (program_abort) begin
      tr_state <= ACI_TR_IDLE;
    end else begin
      case (tr_state)
        ACI_TR_IDLE: begin
          if (program_launch) begin
            tr_state <= trig_input_setting ? ACI_TR_WAITING : ACI_TR_RUNNING;
          end
        end
        ACI_TR_WAITING: begin
          if (trig_rise) begin
            tr_state <= ACI_TR_RUNNING;
          end
        end
        ACI_TR_RUNNING: begin
          if (program_done) begin
            tr_state <= ACI_TR_IDLE;
          end
        end
        default: begin
          tr_state <= ACI_TR_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      transient_running <= 1'b0;
      progress_hold     <= 1'b0;
      transient_start   <= 1'b0;
    end else begin
      transient_running <= (tr_state != ACI_TR_IDLE);
      progress_hold     <= (tr_state == ACI_TR_WAITING);
      transient_start   <= !program_abort && (tr_state == ACI_TR_WAITING) && trig_rise;
    end
  end

  // ----------------------------------------------------------------
  // Phase reference lock
  // ----------------------------------------------------------------
  // Proportional phase nudge plus integral step correction; the step is
  // clamped so a missing or wild reference cannot drag the frequency away.
  logic [PHASE_W-1:0]        range_inc;
  logic signed [PHASE_W-1:0] phase_err;
  logic [PHASE_W-1:0]        err_mag;
  logic signed [PHASE_W+1:0] inc_wide;
  logic signed [PHASE_W+1:0] inc_lo;
  logic signed [PHASE_W+1:0] inc_hi;
  logic [PHASE_W-1:0]        next_inc;
  logic [PHASE_W-1:0]        next_phase_a;
  logic [LOCK_CNT_W-1:0]     lock_cnt;
  logic [TIMEOUT_W-1:0]      ref_timer;
  logic                      ref_timeout;

  assign range_inc = (freq_range_inc == '0) ? RANGE_DEFAULT_INC : freq_range_inc;
  assign phase_err = signed'(phase_a - phase_shift);
  assign err_mag   = phase_err[PHASE_W-1] ? PHASE_W'(-phase_err) : PHASE_W'(phase_err);
  assign inc_lo    = signed'({2'b00, freq_setpoint_inc}) - signed'({2'b00, range_inc});
  assign inc_hi    = signed'({2'b00, freq_setpoint_inc}) + signed'({2'b00, range_inc});
  assign inc_wide  = signed'({2'b00, phase_inc}) - (PHASE_W+2)'(phase_err >>> FREQ_GAIN_SHIFT);
  assign ref_timeout = (ref_timer >= TIMEOUT_W'(REF_TIMEOUT_CYCLES));

  always_comb begin
    next_inc     = phase_inc;
    next_phase_a = phase_a + phase_inc;
    if (!ext_sync_enable) begin
      next_inc = freq_setpoint_inc;
    end else if (ref_rise) begin
      if (inc_wide < inc_lo) begin
        next_inc = PHASE_W'(inc_lo);
      end else if (inc_wide > inc_hi) begin
        next_inc = PHASE_W'(inc_hi);
      end else begin
        next_inc = PHASE_W'(inc_wide);
      end
      next_phase_a = phase_a + phase_inc - PHASE_W'(phase_err >>> PHASE_GAIN_SHIFT);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      phase_inc <= '0;
      phase_a   <= '0;
      phase_b   <= '0;
      phase_c   <= '0;
    end else begin
      phase_inc <= next_inc;
      phase_a   <= next_phase_a;
      phase_b   <= next_phase_a + angle_b;
      phase_c   <= next_phase_a + angle_c;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || !ext_sync_enable || ref_rise) begin
      ref_timer <= '0;
    end else if (!ref_timeout) begin
      ref_timer <= ref_timer + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset || !ext_sync_enable || ref_timeout) begin
      lock_cnt    <= LOCK_CNT_ZERO;
      sync_locked <= 1'b0;
    end else if (ref_rise) begin
      if (err_mag < LOCK_TOL) begin
        if (lock_cnt == LOCK_EDGES) begin
          sync_locked <= 1'b1;
        end else begin
          lock_cnt <= lock_cnt + 1'b1;
        end
      end else begin
        lock_cnt    <= LOCK_CNT_ZERO;
        sync_locked <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_MODE_PRIORITY: assert property (@(posedge clk_sys) disable iff (reset)
    interlock_mode_setting && remote_on_mode_setting |=> interlock_mode == ACI_MODE_INHIBIT)
    else $error("Inhibit setting did not take priority");
  AST_DISABLED_ENABLE: assert property (@(posedge clk_sys) disable iff (reset)
    interlock_mode == ACI_MODE_DISABLED && output_on_cmd && !output_off_cmd && !interlock_fault
    |=> output_enable)
    else $error("Disabled mode refused an enable request");
  AST_INHIBIT_NEEDS_SHORT: assert property (@(posedge clk_sys) disable iff (reset)
    interlock_mode == ACI_MODE_INHIBIT && !ilk_shorted && !output_enable |=> !output_enable)
    else $error("Output enabled in inhibit mode with interlock open");
  AST_INHIBIT_FAULT: assert property (@(posedge clk_sys) disable iff (reset)
    interlock_mode == ACI_MODE_INHIBIT && output_enable && !ilk_shorted
    |=> interlock_fault && !output_enable)
    else $error("Open interlock did not raise a fault");
  AST_REMOTE_ON_FOLLOWS: assert property (@(posedge clk_sys) disable iff (reset)
    interlock_mode == ACI_MODE_REMOTE_ON |=> output_enable == $past(ilk_shorted))
    else $error("Remote-on output does not follow interlock pins");
  AST_NO_TRIGGER_RUNS: assert property (@(posedge clk_sys) disable iff (reset)
    tr_state == ACI_TR_IDLE && program_launch && !program_abort && !trig_input_setting
    |=> ##1 transient_running && !progress_hold)
    else $error("Launch without trigger mode did not run at once");
  AST_EDGE_STARTS: assert property (@(posedge clk_sys) disable iff (reset)
    tr_state == ACI_TR_WAITING && trig_rise && !program_abort
    |=> transient_start ##1 (!transient_start && !progress_hold && transient_running))
    else $error("Trigger edge did not start the transient");
  AST_WAIT_HOLDS: assert property (@(posedge clk_sys) disable iff (reset)
    tr_state == ACI_TR_WAITING && !trig_rise && !program_abort |=> progress_hold && transient_running)
    else $error("Waiting transient did not report zero progress");
  AST_PHASE_OFFSETS: assert property (@(posedge clk_sys) disable iff (reset)
    !reset |=> phase_b == phase_a + $past(angle_b) && phase_c == phase_a + $past(angle_c))
    else $error("Phase B or C not offset from phase A");
  AST_STEP_IN_RANGE: assert property (@(posedge clk_sys) disable iff (reset)
    ext_sync_enable && $past(ext_sync_enable) && $stable(freq_setpoint_inc) && $stable(range_inc)
    |-> signed'({2'b00, phase_inc}) >= inc_lo && signed'({2'b00, phase_inc}) <= inc_hi)
    else $error("Phase step left the permitted range");
  AST_TRIG_SYNC_DELAY: assert property (@(posedge clk_sys) disable iff (reset)
    trig_rise |-> $past(external_trigger_pin, 2) && !$past(external_trigger_pin, 3))
    else $error("Trigger edge seen without two-stage delay");

  COV_INHIBIT_TRIP: cover property (@(posedge clk_sys) disable iff (reset) ilk_trip);
  COV_TRIGGER_START: cover property (@(posedge clk_sys) disable iff (reset) transient_start);
  COV_LOCKED: cover property (@(posedge clk_sys) disable iff (reset) $rose(sync_locked));
  COV_REMOTE_ON: cover property (@(posedge clk_sys) disable iff (reset)
    interlock_mode == ACI_MODE_REMOTE_ON && $rose(output_enable));

endmodule

// ### testbench/aci_far_end.sv
// Behavioural model of the interlock contacts and the trigger and reference pulse sources.
`timescale 1ns/1ps
module aci_far_end (
  input  wire logic        clk_sys,              // System clock, times the pulses and the contact state.
  input  wire logic        contact_closed,       // Interlock contact state asked for by the bench.
  input  wire logic        trig_fire,            // One-cycle request for one trigger pulse.
  input  wire logic        ref_run,              // Reference pulses run while high.
  input  wire logic [15:0] ref_period,           // Reference period in clk_sys cycles.
  output logic             interlock_pins,       // High while the contacts are shorted.
  output logic             external_trigger_pin, // Trigger pulse line.
  output logic             phase_ref_pin         // Reference pulse line.
);
  // ----------------------------------------------------------------
  // Pulse generation
  // ----------------------------------------------------------------
  logic [3:0]  trig_cnt = 4'h0;
  logic [15:0] ref_cnt  = 16'h0;
  logic        closed_q = 1'b0;

  always_ff @(posedge clk_sys) begin
    closed_q <= contact_closed;
  end

  // A request made while the line is low gives a clean low-to-high step held for eight cycles.
  always_ff @(posedge clk_sys) begin
    if (trig_fire) begin
      trig_cnt <= 4'h8;
    end else if (trig_cnt != 4'h0) begin
      trig_cnt <= trig_cnt - 4'h1;
    end
  end

  // The reference stands low between runs so no stray edge appears.
  always_ff @(posedge clk_sys) begin
    if (!ref_run || ref_cnt >= ref_period - 16'h1) begin
      ref_cnt <= 16'h0;
    end else begin
      ref_cnt <= ref_cnt + 16'h1;
    end
  end

  assign interlock_pins       = closed_q;
  assign external_trigger_pin = (trig_cnt != 4'h0);
  assign phase_ref_pin        = ref_run && (ref_cnt < (ref_period >> 1));
endmodule

// ### testbench/aci_ctrl_tb_top.sv
// Self-checking testbench for the auxiliary control input logic.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch at %0t ns: got %h expected %h", $time, (got), (exp)); end end
module aci_ctrl_tb_top;
  import aci_pkg::*;
  // ----------------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------------
  localparam int unsigned TO_CYC  = 100000;
  localparam logic [31:0] SET_INC = 32'h0040_0000;
  logic        clk_sys, reset, contact_closed, trig_fire, ref_run, ilk, trg, refp;
  logic        interlock_mode_setting, remote_on_mode_setting, output_on_cmd, output_off_cmd;
  logic        fault_clear, trig_input_setting, program_launch, program_abort, program_done;
  logic        ext_sync_enable, output_enable, interlock_fault, transient_running;
  logic        progress_hold, transient_start, sync_locked;
  logic [15:0] ref_period;
  logic [31:0] freq_range_inc, phase_shift, angle_b, angle_c, phase_a, phase_b, phase_c, phase_inc;
  aci_mode_t   interlock_mode;
  int          n_mismatch = 0;
  int          n_compared = 0;
  int          cyc_count  = 0;
  int          n_start    = 0;

  aci_far_end far (.clk_sys(clk_sys), .contact_closed(contact_closed), .trig_fire(trig_fire),
    .ref_run(ref_run), .ref_period(ref_period), .interlock_pins(ilk),
    .external_trigger_pin(trg), .phase_ref_pin(refp));

  aci_ctrl #(.REF_TIMEOUT_CYCLES(2000)) dut (.clk_sys(clk_sys), .reset(reset), .interlock_pins(ilk),
    .external_trigger_pin(trg), .phase_ref_pin(refp), .interlock_mode_setting(interlock_mode_setting),
    .remote_on_mode_setting(remote_on_mode_setting), .output_on_cmd(output_on_cmd),
    .output_off_cmd(output_off_cmd), .fault_clear(fault_clear), .trig_input_setting(trig_input_setting),
    .program_launch(program_launch), .program_abort(program_abort), .program_done(program_done),
    .ext_sync_enable(ext_sync_enable), .freq_setpoint_inc(SET_INC), .freq_range_inc(freq_range_inc),
    .phase_shift(phase_shift), .angle_b(angle_b), .angle_c(angle_c), .output_enable(output_enable),
    .interlock_fault(interlock_fault), .interlock_mode(interlock_mode),
    .transient_running(transient_running), .progress_hold(progress_hold),
    .transient_start(transient_start), .sync_locked(sync_locked), .phase_a(phase_a),
    .phase_b(phase_b), .phase_c(phase_c), .phase_inc(phase_inc));

  // ----------------------------------------------------------------
  // Clock, watchdog and helpers
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // A stuck wait must not hang the run, so a lapse counts against it.
  always @(posedge clk_sys) begin
    cyc_count++;
    if (transient_start === 1'b1) n_start++;
    if (cyc_count == TO_CYC) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Bit k: on, off, clear, launch, abort, done, trigger pulse request.
  task automatic pulse(input int k);
    @(posedge clk_sys);
    {trig_fire, program_done, program_abort, program_launch, fault_clear, output_off_cmd,
     output_on_cmd} <= 7'h01 << k;
    @(posedge clk_sys);
    {trig_fire, program_done, program_abort, program_launch, fault_clear, output_off_cmd,
     output_on_cmd} <= 7'h00;
    cyc(5);
  endtask

  task automatic set_pins(input logic inh, input logic rem, input logic closed);
    @(posedge clk_sys);
    interlock_mode_setting <= inh;
    remote_on_mode_setting <= rem;
    contact_closed         <= closed;
    cyc(6);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {reset, contact_closed, trig_fire, ref_run, interlock_mode_setting, remote_on_mode_setting} = 6'h20;
    {output_on_cmd, output_off_cmd, fault_clear, program_launch, program_abort, program_done} = 6'h00;
    {trig_input_setting, ext_sync_enable} = 2'h2;
    {ref_period, freq_range_inc, phase_shift} = {16'd900, 32'h0, 32'h0};
    {angle_b, angle_c} = {32'h5555_5555, 32'haaaa_aaaa};
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    cyc(1);
    `CHK({output_enable, interlock_fault, transient_running, progress_hold, sync_locked}, 5'h00)
    `CHK(interlock_mode, ACI_MODE_DISABLED)
    for (int i = 0; i < 4; i++) begin
      set_pins(i[0], i[1], 1'b0);
      `CHK(interlock_mode, i[0] ? ACI_MODE_INHIBIT : (i[1] ? ACI_MODE_REMOTE_ON : ACI_MODE_DISABLED))
    end
    set_pins(1'b0, 1'b0, 1'b0);
    pulse(0);
    `CHK(output_enable, 1'b1)
    pulse(1);
    `CHK(output_enable, 1'b0)
    set_pins(1'b1, 1'b0, 1'b0);
    pulse(0);
    `CHK(output_enable, 1'b0)
    set_pins(1'b1, 1'b0, 1'b1);
    `CHK(output_enable, 1'b0)
    pulse(0);
    `CHK(output_enable, 1'b1)
    set_pins(1'b1, 1'b0, 1'b0);
    `CHK({output_enable, interlock_fault}, 2'h1)
    pulse(0);
    `CHK(output_enable, 1'b0)
    pulse(2);
    `CHK(interlock_fault, 1'b0)
    set_pins(1'b0, 1'b1, 1'b0);
    `CHK(output_enable, 1'b0)
    set_pins(1'b0, 1'b1, 1'b1);
    `CHK(output_enable, 1'b1)
    pulse(1);
    `CHK(output_enable, 1'b1)
    set_pins(1'b0, 1'b1, 1'b0);
    pulse(0);
    `CHK(output_enable, 1'b0)
    // Trigger: an edge while idle must be ignored.
    pulse(6);
    `CHK({n_start[3:0], transient_running}, 5'h00)
    pulse(3);
    `CHK({transient_running, progress_hold}, 2'h3)
    pulse(6);
    `CHK({n_start[3:0], transient_running, progress_hold}, 6'h06)
    // Let the last pulse fall first, so that a fresh edge reaches the running program.
    cyc(4);
    pulse(6);
    `CHK(n_start[3:0], 4'h1)
    pulse(5);
    `CHK(transient_running, 1'b0)
    pulse(3);
    pulse(4);
    pulse(6);
    `CHK({n_start[3:0], transient_running, progress_hold}, 6'h04)
    // Without trigger mode a launch runs at once, with no wait and no start pulse.
    @(posedge clk_sys);
    trig_input_setting <= 1'b0;
    pulse(3);
    `CHK({n_start[3:0], transient_running, progress_hold}, 6'h06)
    pulse(5);
    `CHK(transient_running, 1'b0)
    // Reference off the setpoint: the step may not leave the default band.
    @(posedge clk_sys);
    ext_sync_enable <= 1'b1;
    ref_run         <= 1'b1;
    for (int i = 0; i < 180; i++) begin
      cyc(50);
      `CHK((phase_inc >= SET_INC - 32'd429) && (phase_inc <= SET_INC + 32'd429), 1'b1)
    end
    `CHK(phase_b, phase_a + angle_b)
    `CHK(phase_c, phase_a + angle_c)
    @(posedge clk_sys);
    {ref_period, freq_range_inc, phase_shift} <= {16'd1024, 32'h0010_0000, 32'h4000_0000};
    for (int i = 0; i < 700 && sync_locked !== 1'b1; i++) cyc(100);
    `CHK(sync_locked, 1'b1)
    `CHK((phase_inc >= SET_INC - 32'h0010_0000) && (phase_inc <= SET_INC + 32'h0010_0000), 1'b1)
    @(posedge clk_sys);
    ref_run <= 1'b0;
    cyc(3000);
    `CHK(sync_locked, 1'b0)
    @(posedge clk_sys);
    ext_sync_enable <= 1'b0;
    cyc(3);
    `CHK(phase_inc, SET_INC)
    print_verdict();
  end
endmodule
